// [rtl/torque_limit_pkg.sv]
/*
 * Constants and types shared by the torque limit and mode selection logic.
 * Assumes torque figures are whole percent of rated torque.
 */
`default_nettype none

package torque_limit_pkg;

	// Torque limit values, percent of rated torque
	localparam int LIMIT_W = 9;
	localparam logic [LIMIT_W-1:0] LIMIT_MAX = 9'h12c;
	localparam logic [LIMIT_W-1:0] RATED_PCT = 9'h064;
	localparam logic [LIMIT_W-1:0] FWD_INT_RESET = 9'h12c;
	localparam logic [LIMIT_W-1:0] REV_INT_RESET = 9'h12c;
	localparam logic [LIMIT_W-1:0] FWD_EXT_RESET = 9'h064;
	localparam logic [LIMIT_W-1:0] REV_EXT_RESET = 9'h064;

	// Setting words and their digit positions
	localparam int SETTING_W = 16;
	localparam logic [SETTING_W-1:0] BASIC_RESET = 16'h0000;
	localparam logic [SETTING_W-1:0] MODE_SET_RESET = 16'h0000;
	localparam int DIR_DIGIT_LSB = 0;
	localparam int TLIM_DIGIT_LSB = 8;
	localparam int MODE_DIGIT_LSB = 4;
	localparam logic [3:0] DIR_CCW_FWD = 4'h0;
	localparam logic [3:0] TLIM_ANALOG = 4'h1;

	// Control mode codes
	localparam logic [3:0] CODE_SPD_ZERO = 4'h3;
	localparam logic [3:0] CODE_SPD_ANA = 4'h4;
	localparam logic [3:0] CODE_SPD_POS = 4'h5;
	localparam logic [3:0] CODE_SPD_TRQ = 4'h6;
	localparam logic [3:0] CODE_POS_SPD = 4'h7;
	localparam logic [3:0] CODE_POS_TRQ = 4'h8;
	localparam logic [3:0] CODE_TRQ_SPD = 4'h9;
	localparam logic [3:0] CODE_SPD_CLAMP = 4'ha;
	localparam logic [3:0] CODE_POS_INH = 4'hb;
	localparam logic [3:0] CODE_POS_CONTACT = 4'hc;
	localparam logic [3:0] CODE_SPD_PARAM = 4'hd;
	localparam logic [3:0] CODE_SPECIAL = 4'he;

	// Analog torque limit scaling: full scale input gives this percent
	localparam logic [LIMIT_W-1:0] ANALOG_FS_PCT = 9'h12c;

	typedef enum logic [3:0] {
		MODE_UNMAPPED,
		MODE_SPEED_CONTACT,
		MODE_SPEED_ZERO_REF,
		MODE_SPEED_ANALOG,
		MODE_POSITION_PULSE,
		MODE_TORQUE_ANALOG,
		MODE_ZERO_CLAMP,
		MODE_POSITION_INHIBIT,
		MODE_POSITION_CONTACT,
		MODE_SPEED_PARAM,
		MODE_SPECIAL
	} ctrl_mode_type;

	typedef enum logic [2:0] {
		SEL_FWD_INTERNAL,
		SEL_REV_INTERNAL,
		SEL_FWD_EXTERNAL,
		SEL_REV_EXTERNAL,
		SEL_BASIC_FUNCTION,
		SEL_CONTROL_MODE
	} param_sel_type;

endpackage : torque_limit_pkg

`default_nettype wire

// [rtl/torque_limit_mode_select.sv]
/*
 * Torque limit selection and control mode pairing for a servo drive.
 * Assumes contact inputs are already synchronous to i_clk, the analog
 * torque reference arrives as a signed two's complement sample, and the
 * motor's maximum torque is given in percent of rated torque.
 * Every output is registered; outputs decoded from the stored settings lag a write by two clocks.
 */
// How it works
// - Forward external limit 0..300, default 100
// - Reverse external limit 0..300, default 100
// - Limits are percent; 100 equals rated torque
// - Forward select low picks external, else internal
// - Reverse select low picks external, else internal
// - Direction digit 0 means forward is CCW
// - Analog option derives limit from analog input
// - Analog limit only in speed or position
// - Analog magnitude applies to both directions
// - Analog limit enabled when digit two is 1
// - Codes 3,4,5,6 pair contact speed modes
// - Codes 7,8 pair pulse position modes
// - Code 9 pairs torque with speed
// - Code A pairs analog speed, zero clamp
// - Code B pairs position with inhibited position
// - Codes C, D, E decode single modes
// - Codes 3..6: both selects high gives alternate
// - Internal limits 0..300, default 300
// - Clamp selected limit to motor maximum
`default_nettype none

module torque_limit_mode_select
	import torque_limit_pkg::*;
#(
	parameter int ANALOG_W = 12
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Parameter writes
	input wire logic i_param_wr,
	input wire param_sel_type i_param_sel,
	input wire logic [SETTING_W-1:0] i_param_data,
	// Contact inputs from the host controller, active low
	input wire logic i_fwd_limit_select_n,
	input wire logic i_rev_limit_select_n,
	input wire logic i_mode_switch_n,
	// Analog torque reference sample and motor data
	input wire logic signed [ANALOG_W-1:0] i_analog_torque_ref,
	input wire logic [LIMIT_W-1:0] i_motor_max_pct,
	// Limits towards the torque loop
	output logic [LIMIT_W-1:0] o_fwd_torque_limit,
	output logic [LIMIT_W-1:0] o_rev_torque_limit,
	output logic o_analog_limit_active,
	// Mode towards the speed and position loops
	output ctrl_mode_type o_active_mode,
	output logic o_mode_alternate,
	output logic o_fwd_is_ccw,
	// Stored settings and write status
	output logic [LIMIT_W-1:0] o_fwd_internal_limit,
	output logic [LIMIT_W-1:0] o_rev_internal_limit,
	output logic [LIMIT_W-1:0] o_fwd_external_limit,
	output logic [LIMIT_W-1:0] o_rev_external_limit,
	output logic [SETTING_W-1:0] o_basic_function_setting,
	output logic [SETTING_W-1:0] o_control_mode_setting,
	output logic o_param_reject
);

	if (ANALOG_W < 2 || ANALOG_W > 16) begin : g_width_check
		$error("ANALOG_W must lie between 2 and 16");
	end

	// Sign bit leaves ANALOG_W-1 bits of magnitude
	localparam int MAG_W = ANALOG_W - 1;
	localparam int PROD_W = MAG_W + LIMIT_W;

	////////////////////////////////////////////////////////////////////////
	// Stored settings

	logic [LIMIT_W-1:0] fwd_internal_limit_ff;
	logic [LIMIT_W-1:0] rev_internal_limit_ff;
	logic [LIMIT_W-1:0] fwd_external_limit_ff;
	logic [LIMIT_W-1:0] rev_external_limit_ff;
	logic [SETTING_W-1:0] basic_function_setting_ff;
	logic [SETTING_W-1:0] control_mode_setting_ff;
	logic param_reject_ff;

	// Range check covers the whole word, so upper bits refuse too
	wire is_limit_sel = (i_param_sel == SEL_FWD_INTERNAL) ||
		(i_param_sel == SEL_REV_INTERNAL) ||
		(i_param_sel == SEL_FWD_EXTERNAL) ||
		(i_param_sel == SEL_REV_EXTERNAL);
	// Out of range limit values are refused and the old value kept
	wire limit_in_range = i_param_data <= {7'h00, LIMIT_MAX};
	wire limit_wr_ok = i_param_wr && is_limit_sel && limit_in_range;
	wire [LIMIT_W-1:0] wr_limit = i_param_data[LIMIT_W-1:0];
	wire nxt_param_reject = i_param_wr && is_limit_sel && !limit_in_range;

	// Settings words are taken whole and never refused
	wire wr_fwd_int = limit_wr_ok && (i_param_sel == SEL_FWD_INTERNAL);
	wire wr_rev_int = limit_wr_ok && (i_param_sel == SEL_REV_INTERNAL);
	wire wr_fwd_ext = limit_wr_ok && (i_param_sel == SEL_FWD_EXTERNAL);
	wire wr_rev_ext = limit_wr_ok && (i_param_sel == SEL_REV_EXTERNAL);
	wire wr_basic = i_param_wr && (i_param_sel == SEL_BASIC_FUNCTION);
	wire wr_mode = i_param_wr && (i_param_sel == SEL_CONTROL_MODE);

	// Internal limits, factory value is the full range
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fwd_internal_limit_ff <= FWD_INT_RESET;
			rev_internal_limit_ff <= REV_INT_RESET;
		end else begin
			if (wr_fwd_int) begin
				fwd_internal_limit_ff <= wr_limit;
			end
			if (wr_rev_int) begin
				rev_internal_limit_ff <= wr_limit;
			end
		end
	end

	// External limits, factory value is rated torque
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fwd_external_limit_ff <= FWD_EXT_RESET;
			rev_external_limit_ff <= REV_EXT_RESET;
		end else begin
			if (wr_fwd_ext) begin
				fwd_external_limit_ff <= wr_limit;
			end
			if (wr_rev_ext) begin
				rev_external_limit_ff <= wr_limit;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			basic_function_setting_ff <= BASIC_RESET;
			control_mode_setting_ff <= MODE_SET_RESET;
			param_reject_ff <= 1'b0;
		end else begin
			if (wr_basic) begin
				basic_function_setting_ff <= i_param_data;
			end
			if (wr_mode) begin
				control_mode_setting_ff <= i_param_data;
			end
			param_reject_ff <= nxt_param_reject;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Setting digits

	// Each setting digit is one hex nibble of its word
	wire [3:0] dir_digit =
		basic_function_setting_ff[DIR_DIGIT_LSB +: 4];
	wire [3:0] tlim_digit =
		basic_function_setting_ff[TLIM_DIGIT_LSB +: 4];
	wire [3:0] mode_code =
		control_mode_setting_ff[MODE_DIGIT_LSB +: 4];

	wire nxt_fwd_is_ccw = dir_digit == DIR_CCW_FWD;
	wire analog_option = tlim_digit == TLIM_ANALOG;

	////////////////////////////////////////////////////////////////////////
	// Control mode pairing

	// First and second mode of the selected pairing
	ctrl_mode_type first_mode;
	ctrl_mode_type second_mode;

	always_comb begin
		case (mode_code)
			CODE_SPD_ZERO: begin
				first_mode = MODE_SPEED_CONTACT;
				second_mode = MODE_SPEED_ZERO_REF;
			end
			CODE_SPD_ANA: begin
				first_mode = MODE_SPEED_CONTACT;
				second_mode = MODE_SPEED_ANALOG;
			end
			CODE_SPD_POS: begin
				first_mode = MODE_SPEED_CONTACT;
				second_mode = MODE_POSITION_PULSE;
			end
			CODE_SPD_TRQ: begin
				first_mode = MODE_SPEED_CONTACT;
				second_mode = MODE_TORQUE_ANALOG;
			end
			CODE_POS_SPD: begin
				first_mode = MODE_POSITION_PULSE;
				second_mode = MODE_SPEED_ANALOG;
			end
			CODE_POS_TRQ: begin
				first_mode = MODE_POSITION_PULSE;
				second_mode = MODE_TORQUE_ANALOG;
			end
			CODE_TRQ_SPD: begin
				first_mode = MODE_TORQUE_ANALOG;
				second_mode = MODE_SPEED_ANALOG;
			end
			CODE_SPD_CLAMP: begin
				first_mode = MODE_SPEED_ANALOG;
				second_mode = MODE_ZERO_CLAMP;
			end
			CODE_POS_INH: begin
				first_mode = MODE_POSITION_PULSE;
				second_mode = MODE_POSITION_INHIBIT;
			end
			CODE_POS_CONTACT: begin
				first_mode = MODE_POSITION_CONTACT;
				second_mode = MODE_POSITION_CONTACT;
			end
			CODE_SPD_PARAM: begin
				first_mode = MODE_SPEED_PARAM;
				second_mode = MODE_SPEED_PARAM;
			end
			CODE_SPECIAL: begin
				first_mode = MODE_SPECIAL;
				second_mode = MODE_SPECIAL;
			end
			default: begin
				// No mode here, which also blocks analog limiting
				first_mode = MODE_UNMAPPED;
				second_mode = MODE_UNMAPPED;
			end
		endcase
	end

	// Contact speed pairs use the two select inputs as the switch
	wire contact_pair = (mode_code == CODE_SPD_ANA) ||
		(mode_code == CODE_SPD_POS) ||
		(mode_code == CODE_SPD_TRQ) ||
		(mode_code == CODE_SPD_ZERO);
	// Both contacts off selects the second mode of the pair
	wire both_selects_off = i_fwd_limit_select_n && i_rev_limit_select_n;
	// Other pairs switch on the separate mode switch contact
	wire nxt_mode_alternate = contact_pair ?
		both_selects_off :
		!i_mode_switch_n;
	wire ctrl_mode_type nxt_active_mode = nxt_mode_alternate ?
		second_mode : first_mode;

	////////////////////////////////////////////////////////////////////////
	// Analog torque limit

	// Most negative sample saturates so the magnitude fits MAG_W bits
	wire sample_neg = i_analog_torque_ref[ANALOG_W-1];
	wire [ANALOG_W-1:0] neg_sample = -i_analog_torque_ref;
	wire [ANALOG_W-1:0] abs_full = sample_neg ?
		neg_sample : i_analog_torque_ref;
	wire [MAG_W-1:0] abs_mag = abs_full[ANALOG_W-1] ?
		{MAG_W{1'b1}} : abs_full[MAG_W-1:0];
	// Full scale magnitude maps to ANALOG_FS_PCT of rated torque
	wire [PROD_W-1:0] ana_product =
		PROD_W'(abs_mag) * PROD_W'(ANALOG_FS_PCT);
	wire [LIMIT_W-1:0] ana_limit = ana_product[PROD_W-1:MAG_W];

	// Analog limiting has no meaning while torque itself is commanded
	wire mode_allows_analog = (nxt_active_mode != MODE_TORQUE_ANALOG) &&
		(nxt_active_mode != MODE_UNMAPPED) &&
		(nxt_active_mode != MODE_SPECIAL);
	wire nxt_analog_limit_active = analog_option &&
		mode_allows_analog;

	////////////////////////////////////////////////////////////////////////
	// Limit selection per direction

	// Contact low selects the external limit
	wire [LIMIT_W-1:0] fwd_param_limit = i_fwd_limit_select_n ?
		fwd_internal_limit_ff : fwd_external_limit_ff;
	wire [LIMIT_W-1:0] rev_param_limit = i_rev_limit_select_n ?
		rev_internal_limit_ff : rev_external_limit_ff;

	// Same analog magnitude bounds both directions
	wire [LIMIT_W-1:0] fwd_with_analog =
		(nxt_analog_limit_active && ana_limit < fwd_param_limit) ?
		ana_limit : fwd_param_limit;
	wire [LIMIT_W-1:0] rev_with_analog =
		(nxt_analog_limit_active && ana_limit < rev_param_limit) ?
		ana_limit : rev_param_limit;

	// A motor cannot exceed its own maximum, whatever is set
	wire [LIMIT_W-1:0] nxt_fwd_torque_limit =
		(fwd_with_analog > i_motor_max_pct) ?
		i_motor_max_pct : fwd_with_analog;
	wire [LIMIT_W-1:0] nxt_rev_torque_limit =
		(rev_with_analog > i_motor_max_pct) ?
		i_motor_max_pct : rev_with_analog;

	////////////////////////////////////////////////////////////////////////
	// Output registers

	logic [LIMIT_W-1:0] fwd_torque_limit_ff;
	logic [LIMIT_W-1:0] rev_torque_limit_ff;
	logic analog_limit_active_ff;
	ctrl_mode_type active_mode_ff;
	logic mode_alternate_ff;
	logic fwd_is_ccw_ff;

	// Reset value is the safest limit: zero torque until first update
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fwd_torque_limit_ff <= '0;
			rev_torque_limit_ff <= '0;
			analog_limit_active_ff <= 1'b0;
		end else begin
			fwd_torque_limit_ff <= nxt_fwd_torque_limit;
			rev_torque_limit_ff <= nxt_rev_torque_limit;
			analog_limit_active_ff <= nxt_analog_limit_active;
		end
	end

	// Direction flag starts in the standard sense, forward is CCW
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			active_mode_ff <= MODE_UNMAPPED;
			mode_alternate_ff <= 1'b0;
			fwd_is_ccw_ff <= 1'b1;
		end else begin
			active_mode_ff <= nxt_active_mode;
			mode_alternate_ff <= nxt_mode_alternate;
			fwd_is_ccw_ff <= nxt_fwd_is_ccw;
		end
	end

	// Outputs straight from their registers
	assign o_fwd_torque_limit = fwd_torque_limit_ff;
	assign o_rev_torque_limit = rev_torque_limit_ff;
	assign o_analog_limit_active = analog_limit_active_ff;
	assign o_active_mode = active_mode_ff;
	assign o_mode_alternate = mode_alternate_ff;
	assign o_fwd_is_ccw = fwd_is_ccw_ff;
	assign o_fwd_internal_limit = fwd_internal_limit_ff;
	assign o_rev_internal_limit = rev_internal_limit_ff;
	assign o_fwd_external_limit = fwd_external_limit_ff;
	assign o_rev_external_limit = rev_external_limit_ff;
	assign o_basic_function_setting = basic_function_setting_ff;
	assign o_control_mode_setting = control_mode_setting_ff;
	assign o_param_reject = param_reject_ff;

endmodule : torque_limit_mode_select

`default_nettype wire

// [bench/torque_limit_assertions.sv]
/* Port assertions for the torque limit and mode selection block.
   Assumes it is bound to the block and sees only its ports. */
`default_nettype none
module torque_limit_assertions
	import torque_limit_pkg::*;
(
	// Clock, reset and writes
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_param_wr,
	input wire param_sel_type i_param_sel,
	input wire logic [SETTING_W-1:0] i_param_data,
	input wire logic i_fwd_limit_select_n,
	input wire logic i_rev_limit_select_n,
	input wire logic [LIMIT_W-1:0] i_motor_max_pct,
	// Observed outputs
	input wire logic [LIMIT_W-1:0] o_fwd_torque_limit,
	input wire logic [LIMIT_W-1:0] o_rev_torque_limit,
	input wire logic o_analog_limit_active,
	input wire ctrl_mode_type o_active_mode,
	input wire logic o_mode_alternate,
	input wire logic o_fwd_is_ccw,
	input wire logic [LIMIT_W-1:0] o_fwd_external_limit,
	input wire logic [LIMIT_W-1:0] o_rev_internal_limit,
	input wire logic [SETTING_W-1:0] o_basic_function_setting,
	input wire logic [SETTING_W-1:0] o_control_mode_setting,
	input wire logic o_param_reject
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	////////////////////////////////////////////////////////////////////////
	wire logic lim_w = i_param_wr && (i_param_sel < SEL_BASIC_FUNCTION);
	wire logic big_w = i_param_data > SETTING_W'(LIMIT_MAX);
	wire logic fx_w = i_param_wr && (i_param_sel == SEL_FWD_EXTERNAL);
	wire logic [3:0] code_w = o_control_mode_setting[7:4];
	wire logic pair_w = code_w inside {CODE_SPD_ANA, CODE_SPD_POS, CODE_SPD_TRQ};
	wire logic both_off_w = i_fwd_limit_select_n && i_rev_limit_select_n;
	function automatic logic [LIMIT_W-1:0] lo(input logic [LIMIT_W-1:0] a,
		input logic [LIMIT_W-1:0] b);
		return (a < b) ? a : b;
	endfunction : lo
	reject_big_a: assert property (lim_w && big_w |=> o_param_reject)
		else $error("over range write not refused");
	fwd_ext_store_a: assert property (fx_w && !big_w
		|=> o_fwd_external_limit == $past(i_param_data[LIMIT_W-1:0]))
		else $error("forward external limit not stored");
	ext_keep_a: assert property (fx_w && big_w
		|=> $stable(o_fwd_external_limit)) else $error("refused write stored");
	fwd_ext_sel_a: assert property (!i_fwd_limit_select_n
		|=> o_analog_limit_active || o_fwd_torque_limit ==
		lo($past(o_fwd_external_limit), $past(i_motor_max_pct)))
		else $error("forward external limit not applied");
	rev_int_sel_a: assert property (i_rev_limit_select_n
		|=> o_analog_limit_active || o_rev_torque_limit ==
		lo($past(o_rev_internal_limit), $past(i_motor_max_pct)))
		else $error("reverse internal limit not applied");
	clamp_max_a: assert property (1'b1 |=>
		o_fwd_torque_limit <= $past(i_motor_max_pct) &&
		o_rev_torque_limit <= $past(i_motor_max_pct))
		else $error("limit above motor maximum");
	ccw_dir_a: assert property (1'b1 |=> o_fwd_is_ccw ==
		($past(o_basic_function_setting[3:0]) == DIR_CCW_FWD))
		else $error("direction flag wrong");
	torque_no_ana_a: assert property (o_active_mode == MODE_TORQUE_ANALOG
		|-> !o_analog_limit_active) else $error("analog limit in torque");
	ana_option_a: assert property (o_analog_limit_active
		|-> $past(o_basic_function_setting[11:8]) == TLIM_ANALOG)
		else $error("analog limit without option");
	pair_alt_a: assert property (pair_w && both_off_w
		|=> o_mode_alternate) else $error("alternate mode not taken");
	pair_first_a: assert property (pair_w && !both_off_w
		|=> !o_mode_alternate && o_active_mode == MODE_SPEED_CONTACT)
		else $error("first mode not taken");
	cover property (o_param_reject);
	cover property (o_analog_limit_active);
	cover property (o_mode_alternate && o_active_mode == MODE_POSITION_INHIBIT);
endmodule : torque_limit_assertions
`default_nettype wire

// [bench/host_contact_model.sv]
/* Host controller model driving the contact and analog reference pins.
   Assumes the bench changes its commands between clock edges. */
`default_nettype none
module host_contact_model #(
	parameter int ANALOG_W = 12
) (
	// Clock and commands from the bench
	input wire logic i_clk,
	input wire logic i_fwd_on,
	input wire logic i_rev_on,
	input wire logic i_switch_on,
	input wire logic signed [ANALOG_W-1:0] i_analog,
	// Pins towards the drive, contacts active low
	output logic o_fwd_limit_select_n,
	output logic o_rev_limit_select_n,
	output logic o_mode_switch_n,
	output logic signed [ANALOG_W-1:0] o_analog_torque_ref
);
	timeunit 1ns;
	timeprecision 1ps;
	// Selects carry the limit function and, in contact speed pairs, the mode switch
	always @(posedge i_clk) begin
		o_fwd_limit_select_n <= !i_fwd_on;
		o_rev_limit_select_n <= !i_rev_on;
		o_mode_switch_n <= !i_switch_on;
		o_analog_torque_ref <= i_analog;
	end
endmodule : host_contact_model
`default_nettype wire

// [bench/tb_torque_limit_mode_select.sv]
/* Self-checking bench for the torque limit and mode selection block.
   Assumes the host model drives pins one clock after each command. */
`default_nettype none
module tb_torque_limit_mode_select import torque_limit_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ANA_W = 12;
	// Half of full scale maps to half of 300 percent
	localparam logic [LIMIT_W-1:0] ANA_HALF =
		LIMIT_W'((32'h400 * 32'h12c) >> (ANA_W - 1));
	logic i_clk = 1'b0;
	logic i_reset_n, i_param_wr, i_mode_switch_n;
	param_sel_type i_param_sel;
	logic [SETTING_W-1:0] i_param_data;
	logic [SETTING_W-1:0] o_basic_function_setting, o_control_mode_setting;
	logic i_fwd_limit_select_n, i_rev_limit_select_n;
	logic signed [ANA_W-1:0] i_analog_torque_ref, ana_cmd;
	logic [LIMIT_W-1:0] i_motor_max_pct, o_fwd_torque_limit, o_rev_torque_limit;
	logic [LIMIT_W-1:0] o_fwd_internal_limit, o_rev_internal_limit;
	logic [LIMIT_W-1:0] o_fwd_external_limit, o_rev_external_limit;
	logic o_analog_limit_active, o_mode_alternate, o_fwd_is_ccw, o_param_reject;
	ctrl_mode_type o_active_mode;
	logic fwd_on, rev_on, sw_on;
	int fails, compares, cycles;
	ctrl_mode_type first_m [3:14] = '{MODE_SPEED_CONTACT,
		MODE_SPEED_CONTACT, MODE_SPEED_CONTACT,
		MODE_SPEED_CONTACT, MODE_POSITION_PULSE, MODE_POSITION_PULSE,
		MODE_TORQUE_ANALOG, MODE_SPEED_ANALOG, MODE_POSITION_PULSE,
		MODE_POSITION_CONTACT, MODE_SPEED_PARAM, MODE_SPECIAL};
	ctrl_mode_type alt_m [3:14] = '{MODE_SPEED_ZERO_REF,
		MODE_SPEED_ANALOG, MODE_POSITION_PULSE,
		MODE_TORQUE_ANALOG, MODE_SPEED_ANALOG, MODE_TORQUE_ANALOG,
		MODE_SPEED_ANALOG, MODE_ZERO_CLAMP, MODE_POSITION_INHIBIT,
		MODE_POSITION_CONTACT, MODE_SPEED_PARAM, MODE_SPECIAL};
	host_contact_model #(.ANALOG_W(ANA_W)) host (.i_clk(i_clk),
		.i_fwd_on(fwd_on), .i_rev_on(rev_on), .i_switch_on(sw_on),
		.i_analog(ana_cmd), .o_fwd_limit_select_n(i_fwd_limit_select_n),
		.o_rev_limit_select_n(i_rev_limit_select_n),
		.o_mode_switch_n(i_mode_switch_n),
		.o_analog_torque_ref(i_analog_torque_ref));
	torque_limit_mode_select #(.ANALOG_W(ANA_W)) dut (.*);
	always #4 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// Whole run is under a thousand cycles
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic settle();
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
	endtask : settle
	task automatic wr(input param_sel_type sel, input logic [15:0] data,
		input logic rej);
		@(posedge i_clk);
		i_param_wr <= 1'b1;
		i_param_sel <= sel;
		i_param_data <= data;
		@(posedge i_clk);
		i_param_wr <= 1'b0;
		@(negedge i_clk);
		check(o_param_reject, rej, "reject");
	endtask : wr
	task automatic contacts(input logic f, input logic r, input logic s);
		fwd_on = f;
		rev_on = r;
		sw_on = s;
		settle();
	endtask : contacts
	task automatic lims(input logic [8:0] f, input logic [8:0] r);
		check(o_fwd_torque_limit, f, "fwd limit");
		check(o_rev_torque_limit, r, "rev limit");
	endtask : lims
	initial begin
		i_reset_n = 1'b0;
		i_param_wr = 1'b0;
		i_param_sel = SEL_FWD_INTERNAL;
		i_param_data = 16'h0000;
		i_motor_max_pct = LIMIT_MAX;
		fwd_on = 1'b0;
		rev_on = 1'b0;
		sw_on = 1'b0;
		ana_cmd = 12'h000;
		repeat (5) @(posedge i_clk);
		@(negedge i_clk);
		check(o_fwd_internal_limit, 16'h012c, "fwd int");
		check(o_rev_internal_limit, 16'h012c, "rev int");
		check(o_fwd_external_limit, 16'h0064, "fwd ext");
		check(o_rev_external_limit, 16'h0064, "rev ext");
		check(o_fwd_torque_limit, 16'h0000, "fwd limit");
		check(o_active_mode, MODE_UNMAPPED, "mode");
		check(o_mode_alternate, 16'h0000, "alt flag");
		check(o_control_mode_setting, 16'h0000, "mode word");
		@(posedge i_clk) i_reset_n <= 1'b1;
		settle();
		lims(9'h12c, 9'h12c);
		check(o_fwd_is_ccw, 16'h0001, "ccw");
		wr(SEL_FWD_EXTERNAL, 16'h0032, 1'b0);
		wr(SEL_REV_EXTERNAL, 16'h00fa, 1'b0);
		wr(SEL_FWD_EXTERNAL, 16'h012d, 1'b1);
		wr(SEL_REV_INTERNAL, 16'h012c, 1'b0);
		wr(SEL_FWD_INTERNAL, 16'h0078, 1'b0);
		check(o_fwd_external_limit, 16'h0032, "fwd ext");
		check(o_rev_external_limit, 16'h00fa, "rev ext");
		contacts(1'b1, 1'b1, 1'b0);
		lims(9'h032, 9'h0fa);
		contacts(1'b0, 1'b1, 1'b0);
		lims(9'h078, 9'h0fa);
		@(posedge i_clk) i_motor_max_pct <= 9'h064;
		settle();
		lims(9'h064, 9'h064);
		@(posedge i_clk) i_motor_max_pct <= LIMIT_MAX;
		wr(SEL_BASIC_FUNCTION, 16'h0001, 1'b0);
		settle();
		check(o_fwd_is_ccw, 16'h0000, "ccw");
		wr(SEL_BASIC_FUNCTION, 16'h0100, 1'b0);
		check(o_basic_function_setting, 16'h0100, "basic");
		wr(SEL_CONTROL_MODE, 16'h0040, 1'b0);
		check(o_control_mode_setting, 16'h0040, "mode word");
		ana_cmd = 12'hc00;
		contacts(1'b0, 1'b0, 1'b0);
		check(o_analog_limit_active, 16'h0001, "analog");
		lims(9'h078, ANA_HALF);
		ana_cmd = 12'h400;
		contacts(1'b0, 1'b0, 1'b0);
		lims(9'h078, ANA_HALF);
		wr(SEL_CONTROL_MODE, 16'h0060, 1'b0);
		settle();
		check(o_analog_limit_active, 16'h0000, "analog");
		wr(SEL_CONTROL_MODE, 16'h0040, 1'b0);
		wr(SEL_BASIC_FUNCTION, 16'h0000, 1'b0);
		settle();
		check(o_analog_limit_active, 16'h0000, "analog");
		for (int c = 3; c <= 14; c++) begin
			wr(SEL_CONTROL_MODE, {8'h00, 4'(c), 4'h0}, 1'b0);
			contacts(1'b0, 1'b0, 1'b1);
			check(o_active_mode, alt_m[c], "alt");
			if (c <= 11) check(o_mode_alternate, 16'h0001, "alt flag");
			contacts(1'b0, 1'b0, 1'b0);
			check(o_active_mode, (c <= 6) ? alt_m[c] : first_m[c],
				"sel");
			contacts(1'b1, 1'b0, 1'b0);
			check(o_active_mode, first_m[c], "first");
			check(o_mode_alternate, 16'h0000, "alt flag");
		end
		wrap_up();
	end
endmodule : tb_torque_limit_mode_select
bind torque_limit_mode_select torque_limit_assertions chk (.*);
`default_nettype wire
